// ### src/mpio_pkg.sv
// constants for the multi-port io block with pin select
// assumes register indices are word indices on a 32-bit apb bus
package mpio_pkg;
   localparam int IDX_W = 12;
   localparam logic [11:0] IDX_ANA_DATA = 12'h006;
   localparam logic [11:0] IDX_LCDA_PIN = 12'h00B;
   localparam logic [11:0] IDX_ANA_DIR = 12'h00C;
   localparam logic [11:0] IDX_PINSEL = 12'hFC0;
   localparam logic [11:0] IDX_P2_LATCH = 12'h010;
   localparam logic [11:0] IDX_P2_PIN = 12'h011;
   localparam logic [11:0] IDX_P3_LATCH = 12'h012;
   localparam logic [11:0] IDX_P3_PIN = 12'h013;
   localparam logic [11:0] IDX_P3_LCD = 12'h014;
   localparam logic [11:0] IDX_LCDA_LATCH = 12'h015;
   localparam logic [11:0] IDX_LCDA_LCD = 12'h016;
   localparam logic [11:0] IDX_LCDB_LATCH = 12'h017;
   localparam logic [11:0] IDX_LCDB_PIN = 12'h018;
   localparam logic [11:0] IDX_LCDB_LCD = 12'h019;
   localparam logic [11:0] IDX_CTRL = 12'h01A;
   localparam logic [2:0] RST_P2 = 3'h7;
   localparam logic [6:0] RST_P3 = 7'h7F;
   localparam logic [7:0] RST_ONES8 = 8'hFF;
   localparam logic [7:0] RST_ZERO8 = 8'h00;
   localparam logic [6:0] RST_ZERO7 = 7'h00;
   localparam logic [6:0] RST_PINSEL = 7'h00;
   localparam logic [2:0] RST_CTRL = 3'h5;
   localparam int CTRL_AIND = 0;
   localparam int CTRL_DUAL = 1;
   localparam int CTRL_GLOBAL_OUTPUT_ENABLE = 2;
   localparam int SEL_IRQ_BASE = 4;
   localparam int FN_P7_BASE = 1;
   localparam int IRQ_P3_BASE = 4;
   localparam int P2_STOP_BIT = 0;
   localparam int P2_LOW_FREQ_CRYSTAL_IN_BIT = 1;
   localparam int P2_LOW_FREQ_CRYSTAL_OUT_BIT = 2;
endpackage

// ### src/mpio_top.sv
// multi-port io: 3-bit, 7-bit, two lcd-capable and one analog port, pin select
// assumes pins synchronous to clk_sys and an apb master on the register side
// Functional notes
// - 3-bit port latch resets to all ones
// - dual clock mode gives upper pins to crystal
// - falling edge of bit 0 sets irq0 latch
// - 3-bit port upper read bits undefined
// - stop mode floats bit 0 regardless of enable
// - 7-bit latch ones, lcd control zero at reset
// - 7-bit lcd bit one drives lcd output
// - 7-bit port bit 7 reads undefined
// - first lcd port latch resets to ones
// - lcd control one routes segment, zero latch
// - separate latch and pin input addresses
// - pin read of segment bit is undefined
// - analog port direction set per bit
// - analog port reset: zeros, disable one
// - direction and data select analog port mode
// - analog mode bits read as zero
// - second lcd port latch resets to ones
// - select bits 6..4 move irq3..irq1 pins
// - select bits 3..0 move timer and divider
//
// Added by the designer: register access over APB.
module mpio_top
   import mpio_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic stop_mode,
   input wire logic [2:0] p2_in,
   output logic [2:0] p2_out,
   output logic [2:0] p2_oe,
   input wire logic [6:0] p3_in,
   output logic [6:0] p3_out,
   output logic [6:0] p3_oe,
   input wire logic [6:0] p3_lcd_drive,
   input wire logic [7:0] lcda_in,
   output logic [7:0] lcda_out,
   output logic [7:0] lcda_oe,
   input wire logic [7:0] lcda_seg,
   input wire logic [7:0] lcdb_in,
   output logic [7:0] lcdb_out,
   output logic [7:0] lcdb_oe,
   input wire logic [7:0] lcdb_seg,
   input wire logic [7:0] p6_in,
   output logic [7:0] p6_out,
   output logic [7:0] p6_oe,
   output logic [7:0] analog_select,
   output logic [7:0] p6_input_data,
   input wire logic [2:0] p1_irq_in,
   input wire logic [3:0] fn_out,
   output logic [3:0] fn_in,
   output logic [2:0] irq_in,
   output logic external_irq0,
   input wire logic low_freq_crystal_out,
   output logic low_freq_crystal_in
);
   // the 12-bit word indices need at least 14 byte-address bits
   if (ADDR_W < 14 || ADDR_W > 32) begin : g_bad_addr_w
      $error("mpio_top: ADDR_W must be 14 to 32");
   end

   logic [2:0] p2_latch;
   logic [6:0] p3_latch;
   logic [6:0] p3_lcd;
   logic [7:0] lcda_latch;
   logic [7:0] lcda_lcd;
   logic [7:0] lcdb_latch;
   logic [7:0] lcdb_lcd;
   logic [7:0] ana_data;
   logic [7:0] ana_dir;
   logic [6:0] pin_sel;
   logic [2:0] ctrl;
   logic [2:0] p2_s;
   logic [6:0] p3_s;
   logic [7:0] lcda_s;
   logic [7:0] lcdb_s;
   logic [7:0] p6_s;
   logic p2_prev;

   // apb decode; word index from paddr[ADDR_W-1:2]
   wire [ADDR_W-3:0] widx = paddr[ADDR_W-1:2];
   wire aligned = (paddr[1:0] == 2'h0);
   wire hit_p2l = aligned && widx == (ADDR_W-2)'(IDX_P2_LATCH);
   wire hit_p2p = aligned && widx == (ADDR_W-2)'(IDX_P2_PIN);
   wire hit_p3l = aligned && widx == (ADDR_W-2)'(IDX_P3_LATCH);
   wire hit_p3p = aligned && widx == (ADDR_W-2)'(IDX_P3_PIN);
   wire hit_p3c = aligned && widx == (ADDR_W-2)'(IDX_P3_LCD);
   wire hit_lal = aligned && widx == (ADDR_W-2)'(IDX_LCDA_LATCH);
   wire hit_lap = aligned && widx == (ADDR_W-2)'(IDX_LCDA_PIN);
   wire hit_lac = aligned && widx == (ADDR_W-2)'(IDX_LCDA_LCD);
   wire hit_lbl = aligned && widx == (ADDR_W-2)'(IDX_LCDB_LATCH);
   wire hit_lbp = aligned && widx == (ADDR_W-2)'(IDX_LCDB_PIN);
   wire hit_lbc = aligned && widx == (ADDR_W-2)'(IDX_LCDB_LCD);
   wire hit_and = aligned && widx == (ADDR_W-2)'(IDX_ANA_DATA);
   wire hit_adr = aligned && widx == (ADDR_W-2)'(IDX_ANA_DIR);
   wire hit_sel = aligned && widx == (ADDR_W-2)'(IDX_PINSEL);
   wire hit_ctl = aligned && widx == (ADDR_W-2)'(IDX_CTRL);
   wire mapped = hit_p2l | hit_p2p | hit_p3l | hit_p3p | hit_p3c | hit_lal | hit_lap | hit_lac
      | hit_lbl | hit_lbp | hit_lbc | hit_and | hit_adr | hit_sel | hit_ctl;
   wire setup = psel & ~penable;
   // write lands only at the completing access edge
   wire wr = psel & penable & pready & pwrite & mapped;
   wire [7:0] wd = pwdata[7:0];

   wire aind = ctrl[CTRL_AIND];
   wire dual = ctrl[CTRL_DUAL];
   wire global_output_enable = ctrl[CTRL_GLOBAL_OUTPUT_ENABLE];

   // analog port mode per bit
   wire [7:0] ana_input_mode = ~ana_dir & ana_data;
   wire [7:0] next_analog_select = ~ana_dir & ~ana_data & {8{~aind}};
   // fixed-zero and analog bits both read zero, so no stale pin leaks in
   wire [7:0] ana_read = (ana_dir & ana_data) | (ana_input_mode & p6_s);
   wire [7:0] next_p6_oe = {8{global_output_enable}} & ana_dir;

   // timer/divider value per pin; one means release (open drain)
   wire [6:0] p3_fn;
   wire [7:0] lcdb_fn;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_p3fn
         if (g < 4) begin : g_sel
            assign p3_fn[g] = pin_sel[g] ? 1'b1 : fn_out[g];
         end else begin : g_none
            assign p3_fn[g] = 1'b1;
         end
      end
      for (g = 0; g < 8; g++) begin : g_lbfn
         if (g >= FN_P7_BASE && g < FN_P7_BASE + 4) begin : g_sel
            assign lcdb_fn[g] = pin_sel[g-FN_P7_BASE] ? fn_out[g-FN_P7_BASE] : 1'b1;
         end else begin : g_none
            assign lcdb_fn[g] = 1'b1;
         end
      end
   endgenerate

   // open-drain port drive, push-pull while a bit is an lcd output
   wire [6:0] p3_val = p3_latch & p3_fn;
   wire [6:0] next_p3_out = p3_lcd & p3_lcd_drive;
   wire [6:0] next_p3_oe = {7{global_output_enable}} & (p3_lcd | ~p3_val);
   wire [7:0] next_lcda_out = lcda_lcd & lcda_seg;
   wire [7:0] next_lcda_oe = {8{global_output_enable}} & (lcda_lcd | ~lcda_latch);
   wire [7:0] lcdb_val = lcdb_latch & lcdb_fn;
   wire [7:0] next_lcdb_out = lcdb_lcd & lcdb_seg;
   wire [7:0] next_lcdb_oe = {8{global_output_enable}} & (lcdb_lcd | ~lcdb_val);

   // 3-bit port: crystal pins in dual mode, stop pin floats in stop mode
   wire [2:0] p2_od_oe = {3{global_output_enable}} & ~p2_latch;
   wire [2:0] next_p2_oe;
   wire [2:0] next_p2_out;
   assign next_p2_oe[P2_STOP_BIT] = stop_mode ? 1'b0 : p2_od_oe[P2_STOP_BIT];
   assign next_p2_oe[P2_LOW_FREQ_CRYSTAL_IN_BIT] = dual ? 1'b0 : p2_od_oe[P2_LOW_FREQ_CRYSTAL_IN_BIT];
   assign next_p2_oe[P2_LOW_FREQ_CRYSTAL_OUT_BIT] = dual ? 1'b1 : p2_od_oe[P2_LOW_FREQ_CRYSTAL_OUT_BIT];
   assign next_p2_out[P2_STOP_BIT] = 1'b0;
   assign next_p2_out[P2_LOW_FREQ_CRYSTAL_IN_BIT] = 1'b0;
   assign next_p2_out[P2_LOW_FREQ_CRYSTAL_OUT_BIT] = dual & low_freq_crystal_out;
   // pin falling edge, driven or not, sets the irq0 latch
   wire next_irq0 = p2_prev & ~p2_s[P2_STOP_BIT];

   // routed inputs
   wire [2:0] next_irq_in;
   wire [3:0] next_fn_in;
   generate
      for (g = 0; g < 3; g++) begin : g_irq
         assign next_irq_in[g] = pin_sel[SEL_IRQ_BASE+g] ? p3_s[IRQ_P3_BASE+g] : p1_irq_in[g];
      end
      for (g = 0; g < 4; g++) begin : g_fnin
         assign next_fn_in[g] = pin_sel[g] ? lcdb_s[FN_P7_BASE+g] : p3_s[g];
      end
   endgenerate

   // read mux; upper unimplemented bits return zero
   wire [7:0] rd_value =
      hit_p2l ? {5'h00, p2_latch} :
      hit_p2p ? {5'h00, p2_s} :
      hit_p3l ? {1'b0, p3_latch} :
      hit_p3p ? {1'b0, p3_s} :
      hit_p3c ? {1'b0, p3_lcd} :
      hit_lal ? lcda_latch :
      hit_lap ? lcda_s :
      hit_lac ? lcda_lcd :
      hit_lbl ? lcdb_latch :
      hit_lbp ? lcdb_s :
      hit_lbc ? lcdb_lcd :
      hit_and ? ana_read :
      hit_adr ? ana_dir :
      hit_sel ? {1'b0, pin_sel} :
      hit_ctl ? {5'h00, ctrl} : 8'h00;

   // no wait state: pready rises in the first access cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= setup ? {24'h000000, rd_value} : 32'h00000000;
      end
   end

   // one short block per register; writes land only at the completing access edge
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         p2_latch <= RST_P2;
      end else if (wr && hit_p2l) begin
         p2_latch <= wd[2:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         p3_latch <= RST_P3;
      end else if (wr && hit_p3l) begin
         p3_latch <= wd[6:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         p3_lcd <= RST_ZERO7;
      end else if (wr && hit_p3c) begin
         p3_lcd <= wd[6:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lcda_latch <= RST_ONES8;
      end else if (wr && hit_lal) begin
         lcda_latch <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lcda_lcd <= RST_ZERO8;
      end else if (wr && hit_lac) begin
         lcda_lcd <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lcdb_latch <= RST_ONES8;
      end else if (wr && hit_lbl) begin
         lcdb_latch <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lcdb_lcd <= RST_ZERO8;
      end else if (wr && hit_lbc) begin
         lcdb_lcd <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ana_data <= RST_ZERO8;
      end else if (wr && hit_and) begin
         // whole-byte write; a read-back merge would corrupt mode bits
         ana_data <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ana_dir <= RST_ZERO8;
      end else if (wr && hit_adr) begin
         ana_dir <= wd;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pin_sel <= RST_PINSEL;
      end else if (wr && hit_sel) begin
         pin_sel <= wd[6:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl <= RST_CTRL;
      end else if (wr && hit_ctl) begin
         ctrl <= wd[2:0];
      end
   end

   // pin sampling, pins already synchronous
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         p2_s <= RST_P2;
         p2_prev <= 1'b1;
         p3_s <= RST_ZERO7;
         lcda_s <= RST_ZERO8;
         lcdb_s <= RST_ZERO8;
         p6_s <= RST_ZERO8;
      end else begin
         p2_s <= p2_in;
         p2_prev <= p2_s[P2_STOP_BIT];
         p3_s <= p3_in;
         lcda_s <= lcda_in;
         lcdb_s <= lcdb_in;
         p6_s <= p6_in;
      end
   end

   // registered pin outputs: 3-bit and 7-bit ports
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         p2_out <= 3'h0;
         p2_oe <= 3'h0;
         p3_out <= RST_ZERO7;
         p3_oe <= RST_ZERO7;
      end else begin
         p2_out <= next_p2_out;
         p2_oe <= next_p2_oe;
         p3_out <= next_p3_out;
         p3_oe <= next_p3_oe;
      end
   end

   // lcd-capable port pins
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lcda_out <= RST_ZERO8;
         lcda_oe <= RST_ZERO8;
         lcdb_out <= RST_ZERO8;
         lcdb_oe <= RST_ZERO8;
      end else begin
         lcda_out <= next_lcda_out;
         lcda_oe <= next_lcda_oe;
         lcdb_out <= next_lcdb_out;
         lcdb_oe <= next_lcdb_oe;
      end
   end

   // analog port; input data stays zero until a bit enters input mode
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         p6_out <= RST_ZERO8;
         p6_oe <= RST_ZERO8;
         analog_select <= RST_ZERO8;
         p6_input_data <= RST_ZERO8;
      end else begin
         p6_out <= ana_data;
         p6_oe <= next_p6_oe;
         analog_select <= next_analog_select;
         p6_input_data <= ana_input_mode & p6_s;
      end
   end

   // routed function inputs, irq0 pulse and crystal input
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         fn_in <= 4'h0;
         irq_in <= 3'h0;
         external_irq0 <= 1'b0;
         low_freq_crystal_in <= 1'b0;
      end else begin
         fn_in <= next_fn_in;
         irq_in <= next_irq_in;
         external_irq0 <= next_irq0;
         low_freq_crystal_in <= dual & p2_s[P2_LOW_FREQ_CRYSTAL_IN_BIT];
      end
   end
endmodule // mpio_top

// ### testbench/mpio_pins.sv
// pin model: open-drain ports released to pull-up, analog port driven from outside
// assumes pad vectors packed as {p6, lcd b, lcd a, 7-bit, 3-bit}
module mpio_pins (
   input wire logic [33:0] pad_out,
   input wire logic [33:0] pad_oe,
   input wire logic [33:0] ext_level,
   output logic [33:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // released pins show the outside level, never the last driven one
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule // mpio_pins

// ### testbench/mpio_properties.sv
// checker for mpio_top: apb answer timing, stop gating, irq0 edge, analog modes
// assumes it is bound to mpio_top and sees its ports only
module mpio_checker (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic stop_mode,
   input wire logic [2:0] p2_in,
   input wire logic [2:0] p2_oe,
   input wire logic external_irq0,
   input wire logic [7:0] p6_oe,
   input wire logic [7:0] analog_select,
   input wire logic [7:0] p6_input_data
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   setup_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not one cycle after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   stop_floats_a: assert property (stop_mode && $past(stop_mode) |-> !p2_oe[0])
      else $error("bit 0 driven in stop");
   irq0_on_fall_a: assert property ($fell(p2_in[0]) |-> ##[1:2] external_irq0)
      else $error("no irq0 after falling bit 0");
   irq0_pulse_a: assert property (external_irq0 |=> !external_irq0)
      else $error("irq0 longer than one cycle");
   analog_exclusive_a: assert property ((analog_select & (p6_oe | p6_input_data)) == 8'h0)
      else $error("analog bit also output or input");
   input_not_output_a: assert property ((p6_input_data & p6_oe) == 8'h0)
      else $error("output bit feeds input data");
endmodule // mpio_checker
bind mpio_top mpio_checker mpio_checker_i (.clk_sys, .rstn, .psel, .penable, .prdata, .pready, .pslverr,
   .stop_mode, .p2_in, .p2_oe, .external_irq0, .p6_oe, .analog_select, .p6_input_data);

// ### testbench/mpio_tb_top.sv
// bench for mpio_top: apb master, pin model, random stimulus
// assumes checker and pin model are compiled first
module mpio_tb_top import mpio_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0, low_freq_crystal_out = 0;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, r;
   logic [6:0] p3_lcd_drive = '0, s;
   logic [7:0] lcda_seg = '0, lcdb_seg = '0, d, v;
   logic [2:0] p1_irq_in = '0;
   logic [3:0] fn_out = '1;
   logic [33:0] ext = '1;
   logic e, seen;
   wire [33:0] pout, poe, pin;
   wire [31:0] prdata;
   wire pready, pslverr, external_irq0, low_freq_crystal_in;
   wire [7:0] analog_select, p6_input_data;
   wire [3:0] fn_in;
   wire [2:0] irq_in;
   int error_cnt = 0, checked = 0;
   logic [11:0] ri [11] = '{IDX_P2_LATCH, IDX_P3_LATCH, IDX_P3_LCD, IDX_LCDA_LATCH, IDX_LCDA_LCD,
      IDX_LCDB_LATCH, IDX_LCDB_LCD, IDX_ANA_DATA, IDX_ANA_DIR, IDX_PINSEL, IDX_CTRL};
   logic [7:0] rv [11] = '{8'h07, 8'h7F, 8'h0, 8'hFF, 8'h0, 8'hFF, 8'h0, 8'h0, 8'h0, 8'h0, 8'h05};
   logic [7:0] rm [11] = '{8'h07, 8'h7F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0, 8'hFF, 8'h7F, 8'h07};
   mpio_top mpio_top_i (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .stop_mode, .p2_in(pin[2:0]), .p2_out(pout[2:0]), .p2_oe(poe[2:0]), .p3_in(pin[9:3]), .p3_out(pout[9:3]),
      .p3_oe(poe[9:3]), .p3_lcd_drive, .lcda_in(pin[17:10]), .lcda_out(pout[17:10]), .lcda_oe(poe[17:10]),
      .lcda_seg, .lcdb_in(pin[25:18]), .lcdb_out(pout[25:18]), .lcdb_oe(poe[25:18]), .lcdb_seg,
      .p6_in(pin[33:26]), .p6_out(pout[33:26]), .p6_oe(poe[33:26]), .analog_select, .p6_input_data,
      .p1_irq_in, .fn_out, .fn_in, .irq_in, .external_irq0, .low_freq_crystal_out, .low_freq_crystal_in);
   mpio_pins mpio_pins_i (.pad_out(pout), .pad_oe(poe), .ext_level(ext), .pad_in(pin));
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic apb(input logic [11:0] idx, input logic w, input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never reassigns psel in this step
      @(posedge clk_sys);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdc(input string what, input logic [11:0] idx, input logic [31:0] exp);
      apb(idx, 1'b0, 8'h0);
      chk(what, exp, r);
   endtask
   // {irq_in, fn_in, 7-bit pins 3..0, lcd b pins 4..1}; open drain, so a pin is low only if driven
   function automatic logic [14:0] route(logic [6:0] sel, logic [3:0] f, logic [2:0] x, p1);
      return {sel[6:4] & x | ~sel[6:4] & p1, f, sel[3:0] | f, ~sel[3:0] | f};
   endfunction
   task automatic wrap_up();
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'hD370));
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      foreach (ri[i]) rdc("reset value", ri[i], 32'(rv[i]));
      chk("input data reset", 32'h0, 32'(p6_input_data));
      apb(12'h020, 1'b0, 8'h0);
      chk("unmapped error", 32'h1, 32'(e));
      foreach (ri[i]) begin
         if (rm[i] != 8'h0) begin
            d = 8'($urandom()) & rm[i];
            apb(ri[i], 1'b1, d);
            rdc("readback", ri[i], 32'(d));
            apb(ri[i], 1'b1, rv[i]);
         end
      end
      repeat (12) begin
         s = 7'($urandom());
         p1_irq_in <= 3'($urandom());
         fn_out <= 4'($urandom());
         ext[9:7] <= 3'($urandom());
         low_freq_crystal_out <= 1'($urandom());
         apb(IDX_PINSEL, 1'b1, {1'b0, s});
         repeat (4) @(posedge clk_sys);
         chk("routing", 32'(route(s, fn_out, ext[9:7], p1_irq_in)),
            32'({irq_in, fn_in, pin[6:3], pin[22:19]}));
      end
      apb(IDX_P2_LATCH, 1'b1, 8'h06);
      seen = 1'b0;
      repeat (6) begin
         @(posedge clk_sys);
         seen = seen | external_irq0;
      end
      chk("irq0 pulse", 32'h1, 32'(seen));
      stop_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("stop oe", 32'h0, 32'(poe[0]));
      stop_mode <= 1'b0;
      ext[33:10] <= 24'($urandom()); // held steady through the analog checks
      for (int a = 0; a < 2; a++) begin
         d = 8'($urandom());
         v = 8'($urandom());
         apb(IDX_CTRL, 1'b1, a ? 8'h04 : 8'h05);
         apb(IDX_ANA_DIR, 1'b1, d);
         apb(IDX_ANA_DATA, 1'b1, v);
         repeat (3) @(posedge clk_sys);
         chk("analog select", 32'(~d & ~v & {8{a[0]}}), 32'(analog_select));
         chk("input data", 32'(~d & v & pin[33:26]), 32'(p6_input_data));
         chk("p6 oe", 32'(d), 32'(poe[33:26]));
         rdc("analog read", IDX_ANA_DATA, 32'(v & (d | pin[33:26])));
      end
      rdc("pin read", IDX_LCDA_PIN, 32'(pin[17:10]));
      p3_lcd_drive <= 7'($urandom());
      lcda_seg <= 8'($urandom());
      lcdb_seg <= 8'($urandom());
      apb(IDX_P3_LCD, 1'b1, 8'h7F);
      apb(IDX_LCDA_LCD, 1'b1, 8'hFF);
      apb(IDX_LCDB_LCD, 1'b1, 8'hFF);
      repeat (3) @(posedge clk_sys);
      chk("lcd out", {8'h0, lcdb_seg, lcda_seg, 1'b0, p3_lcd_drive},
         {8'h0, pout[25:10], 1'b0, pout[9:3]});
      chk("crystal in single", 32'h0, 32'(low_freq_crystal_in));
      low_freq_crystal_out <= 1'($urandom());
      ext[1] <= 1'($urandom());
      apb(IDX_CTRL, 1'b1, 8'h07);
      repeat (3) @(posedge clk_sys);
      chk("crystal in", 32'(ext[1]), 32'(low_freq_crystal_in));
      chk("crystal pins", 32'({1'b1, low_freq_crystal_out, 1'b0}), 32'({poe[2], pout[2], poe[1]}));
      wrap_up();
   end
endmodule // mpio_tb_top
